/* i2c_start_control_and_bus_init_test.sv */
/*
 file: self-checking bench of the start-control and bus-init block.
 assumes: scbi_pkg, scbi_top and scbi_peer compiled before.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_start_control_and_bus_init_test;
	import scbi_pkg::*;
	logic i_mclk, i_rst_n, i_wr, i_rd, i_arb_lost;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata, d;
	logic o_irq, o_sda_out, o_sda_oe, o_scl_out, o_scl_oe, p_sda_oe, p_scl_oe;
	wire logic sda, scl;
	int fails, cmp_count, k, n;
	assign sda = (o_sda_oe ? o_sda_out : 1'b1) & ~p_sda_oe;
	assign scl = (o_scl_oe ? o_scl_out : 1'b1) & ~p_scl_oe;
	scbi_top u_scbi_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_sda(sda), .i_scl(scl),
		.i_arb_lost(i_arb_lost), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_scl_out(o_scl_out),
		.o_scl_oe(o_scl_oe));
	scbi_peer u_scbi_peer (.o_sda_oe(p_sda_oe), .o_scl_oe(p_scl_oe));
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	// ************************************************************
	// bus cycles and comparisons
	// ************************************************************
	task automatic end_of_test();
		if (fails == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic do_reset();
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
	endtask
	task automatic cycles(input int c);
		repeat (c) @(posedge i_mclk);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset_values();
		logic [3:0] a;
		do_reset();
		chk1("irq", 1'b0, o_irq);
		chk1("sda_oe", 1'b0, o_sda_oe);
		chk1("scl_oe", 1'b0, o_scl_oe);
		for (int i = 0; i < 7; i++) begin
			a = (i == 6) ? 4'hf : 4'(i);
			rd(a, d);
			chk8("reset_byte", SCBI_RST_BYTE, d);
		end
	endtask
	task automatic t_busy_on_enable();
		do_reset();
		wr(SCBI_OFF_FLAG, 8'h02);
		wr(SCBI_OFF_CTRL, 8'h80);
		rd(SCBI_OFF_FLAG, d);
		chk1("busy_opt1", 1'b0, d[SCBI_FLAG_BUSY]);
		wr(SCBI_OFF_CTRL, 8'h00);
		wr(SCBI_OFF_CLK, 8'h00);
		wr(SCBI_OFF_FLAG, 8'h00);
		wr(SCBI_OFF_CTRL, 8'h80);
		rd(SCBI_OFF_FLAG, d);
		chk1("busy_opt0", 1'b1, d[SCBI_FLAG_BUSY]);
		wr(SCBI_OFF_CTRL, 8'h81);
		u_scbi_peer.stop();
		cycles(10);
		rd(SCBI_OFF_STAT, d);
		chk1("stop_seen", 1'b1, d[SCBI_STAT_STOPD]);
		rd(SCBI_OFF_FLAG, d);
		chk1("busy_after_stop", 1'b0, d[SCBI_FLAG_BUSY]);
	endtask
	task automatic t_start_wait();
		for (int s = 0; s < 4; s++) begin
			n = (s == 2) ? 12 : (s == 3) ? 3 : 6;
			do_reset();
			wr(SCBI_OFF_CLK, 8'(s));
			wr(SCBI_OFF_FLAG, 8'h03);
			wr(SCBI_OFF_CTRL, 8'h80);
			wr(SCBI_OFF_CLK, 8'(~s & 3));
			cycles(76);
			chk1("lines_idle", 1'b1, sda && scl);
			wr(SCBI_OFF_CTRL, 8'h82);
			k = 0;
			while (o_sda_oe !== 1'b1 && k < 40) begin
				@(posedge i_mclk);
				k++;
			end
			chk1("start_latency", 1'b1, k >= n && k <= n + 4);
			rd(SCBI_OFF_FLAG, d);
			chk1("start_outcome_flag", 1'b1, d[SCBI_FLAG_START_OUTCOME_FLAG]);
			rd(SCBI_OFF_IRQ, d);
			chk1("start_outcome_flag_event", 1'b1, d[SCBI_EV_START_OUTCOME_FLAG]);
			rd(SCBI_OFF_STAT, d);
			chk1("master_status", 1'b1, d[SCBI_STAT_MST]);
		end
	endtask
	task automatic t_reject();
		do_reset();
		wr(SCBI_OFF_FLAG, 8'h03);
		wr(SCBI_OFF_CTRL, 8'h80);
		fork
			u_scbi_peer.frame();
		join_none
		cycles(10);
		i_arb_lost <= 1'b1;
		@(posedge i_mclk);
		i_arb_lost <= 1'b0;
		wr(SCBI_OFF_CTRL, 8'h82);
		cycles(20);
		chk1("no_start", 1'b0, o_sda_oe);
		chk1("irq_masked", 1'b0, o_irq);
		wr(SCBI_OFF_MASK, 8'h02);
		cycles(2);
		chk1("irq_raised", 1'b1, o_irq);
		rd(SCBI_OFF_IRQ, d);
		chk1("reject_event", 1'b1, d[SCBI_EV_REJ]);
		chk1("no_start_outcome_flag_event", 1'b0, d[SCBI_EV_START_OUTCOME_FLAG]);
		@(posedge i_mclk);
		#1 chk1("irq_cleared", 1'b0, o_irq);
		rd(SCBI_OFF_FLAG, d);
		chk1("start_outcome_flag_rejected", 1'b0, d[SCBI_FLAG_START_OUTCOME_FLAG]);
		cycles(80);
		u_scbi_peer.stop();
	endtask
	task automatic t_reserve();
		do_reset();
		wr(SCBI_OFF_FLAG, 8'h02);
		wr(SCBI_OFF_CTRL, 8'h90);
		fork
			u_scbi_peer.frame();
		join_none
		cycles(10);
		wr(SCBI_OFF_CTRL, 8'h92);
		cycles(80);
		chk1("held_reserved", 1'b0, o_sda_oe);
		rd(SCBI_OFF_IRQ, d);
		chk1("not_rejected", 1'b0, d[SCBI_EV_REJ]);
		u_scbi_peer.stop();
		k = 0;
		while (o_sda_oe !== 1'b1 && k < 60) begin
			@(posedge i_mclk);
			k++;
		end
		chk1("reserved_start", 1'b1, o_sda_oe);
		rd(SCBI_OFF_IRQ, d);
		chk1("stop_event", 1'b1, d[SCBI_EV_STOP]);
	endtask
	task automatic t_join_busy();
		do_reset();
		wr(SCBI_OFF_FLAG, 8'h00);
		u_scbi_peer.sda_low();
		cycles(6);
		wr(SCBI_OFF_CTRL, 8'h80);
		cycles(6);
		rd(SCBI_OFF_STAT, d);
		chk1("start_seen", 1'b1, d[SCBI_STAT_STARTD]);
		wr(SCBI_OFF_CTRL, 8'hc0);
		cycles(4);
		chk1("no_ack", 1'b0, o_sda_oe);
		repeat (2) u_scbi_peer.clock_pulse();
		u_scbi_peer.sda_free();
		cycles(6);
		rd(SCBI_OFF_FLAG, d);
		chk1("busy_freed", 1'b0, d[SCBI_FLAG_BUSY]);
	endtask
	initial begin
		i_rst_n = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_arb_lost = 1'b0;
		fails = 0;
		cmp_count = 0;
		t_reset_values();
		t_busy_on_enable();
		t_start_wait();
		t_reject();
		t_reserve();
		t_join_busy();
		end_of_test();
	end
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
endmodule // i2c_start_control_and_bus_init_test
`default_nettype wire

/* scbi_link.sv */
/*
 file: start-condition generator on the data pin; the clock-pin enable is only ever cleared.
 assumes: clean synchronised levels; open-drain outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module scbi_link
	import scbi_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_go_start,
	input wire logic i_go_stop,
	input wire logic i_release,
	output logic o_sda_oe,
	output logic o_scl_oe,
	output logic o_master
);
	// ************************************************************
	// pin drive: start pulls data low, stop releases it
	// ************************************************************
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sda_oe <= 1'b0;
			o_scl_oe <= 1'b0;
			o_master <= 1'b0;
		end else if (i_release || i_go_stop) begin
			o_sda_oe <= 1'b0;
			o_scl_oe <= 1'b0;
			o_master <= 1'b0;
		end else if (i_go_start) begin
			o_sda_oe <= 1'b1;
			o_master <= 1'b1;
		end
	end
endmodule // scbi_link
`default_nettype wire

/* scbi_peer.sv */
/*
 file: far-side two-wire device model driving the open-drain lines.
 assumes: the bench resolves the lines with pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none
module scbi_peer (
	output logic o_sda_oe,
	output logic o_scl_oe
);
	localparam int HALF = 160;
	initial begin
		o_sda_oe = 1'b0;
		o_scl_oe = 1'b0;
	end
	// ************************************************************
	// start condition, then one byte 0x55 at the link rate
	// ************************************************************
	task automatic frame();
		logic [7:0] b;
		b = 8'h55;
		o_sda_oe = 1'b1;
		#HALF;
		for (int i = 0; i < 9; i++) begin
			o_scl_oe = 1'b1;
			#20;
			o_sda_oe = (i < 8) ? ~b[7 - i] : 1'b0;
			#(HALF - 20);
			o_scl_oe = 1'b0;
			#HALF;
		end
		o_scl_oe = 1'b1;
	endtask
	// stop condition, lines left released
	task automatic stop();
		o_sda_oe = 1'b1;
		#HALF;
		o_scl_oe = 1'b0;
		#HALF;
		o_sda_oe = 1'b0;
	endtask
	task automatic sda_low();
		o_sda_oe = 1'b1;
	endtask
	task automatic sda_free();
		o_sda_oe = 1'b0;
	endtask
	// one clock pulse, used to free a data line held low
	task automatic clock_pulse();
		o_scl_oe = 1'b1;
		#HALF;
		o_scl_oe = 1'b0;
		#HALF;
	endtask
endmodule // scbi_peer
`default_nettype wire

/* scbi_pkg.sv */
/*
 file: shared constants of the start-control and bus-init block.
 assumes: included before the other design files.
*/
package scbi_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [3:0] SCBI_OFF_CTRL = 4'h0;
	localparam logic [3:0] SCBI_OFF_CLK = 4'h1;
	localparam logic [3:0] SCBI_OFF_FLAG = 4'h2;
	localparam logic [3:0] SCBI_OFF_STAT = 4'h3;
	localparam logic [3:0] SCBI_OFF_IRQ = 4'h4;
	localparam logic [3:0] SCBI_OFF_MASK = 4'h5;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int SCBI_CTRL_STOP = 0;
	localparam int SCBI_CTRL_START = 1;
	localparam int SCBI_CTRL_SPIE = 4;
	localparam int SCBI_CTRL_REL = 6;
	localparam int SCBI_CTRL_EN = 7;
	localparam int SCBI_FLAG_RSVD = 0;
	localparam int SCBI_FLAG_START_ON_ENABLE_OPTION = 1;
	localparam int SCBI_FLAG_BUSY = 6;
	localparam int SCBI_FLAG_START_OUTCOME_FLAG = 7;
	localparam int SCBI_STAT_STOPD = 0;
	localparam int SCBI_STAT_STARTD = 1;
	localparam int SCBI_STAT_EXC = 5;
	localparam int SCBI_STAT_MST = 7;
	localparam int SCBI_EV_START_OUTCOME_FLAG = 0;
	localparam int SCBI_EV_REJ = 1;
	localparam int SCBI_EV_STOP = 2;
	localparam int SCBI_EV_START = 3;
	// ************************************************************
	// reset values and timing counts
	// ************************************************************
	localparam logic [7:0] SCBI_RST_BYTE = 8'h00;
	localparam logic [3:0] SCBI_WAIT_00 = 4'h6;
	localparam logic [3:0] SCBI_WAIT_01 = 4'h6;
	localparam logic [3:0] SCBI_WAIT_10 = 4'hc;
	localparam logic [3:0] SCBI_WAIT_11 = 4'h3;
	localparam logic [3:0] SCBI_EXT_CODE = 4'hf;
	typedef enum logic [1:0] {SCBI_IDLE, SCBI_WAITING, SCBI_HOLD} scbi_state_e;
	function automatic logic [3:0] scbi_wait(input logic [1:0] sel);
		unique case (sel)
			2'b00: scbi_wait = SCBI_WAIT_00;
			2'b01: scbi_wait = SCBI_WAIT_01;
			2'b10: scbi_wait = SCBI_WAIT_10;
			2'b11: scbi_wait = SCBI_WAIT_11;
		endcase
	endfunction
endpackage

/* scbi_sync.sv */
/*
 file: three-flop input synchroniser with agreement filter.
 assumes: asynchronous pin input, i_mclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module scbi_sync (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_level
);
	logic s1_reg, s2_reg, s3_reg;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			o_level <= 1'b1;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				o_level <= s3_reg;
			end
		end
	end
endmodule // scbi_sync
`default_nettype wire

/* scbi_top.sv */
/*
 file: start-request control and enable-time bus state of a two-wire controller.
 assumes: single clock i_mclk, plain register port, open-drain pins resolved outside.
*/
// Notes on behaviour
// - reserving off: reject start when not participating
// - non-participation: lost arbitration, or extension released
// - start-outcome flag set when start generated; code sets it after any unrejected wait, even while busy_reg defers the start
// - flag valid after 6/6/12/3 clocks by select
// - option 0: busy set on enable
// - option 1: busy cleared on enable
// - multi-master: no master until stop seen
// - enable during data low, clock high: start
// - reserved transfer waits for stop condition
// - reserving on: busy start becomes reservation
`timescale 1ns/10ps
`default_nettype none
module scbi_top
	import scbi_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq,
	input wire logic i_sda,
	input wire logic i_scl,
	input wire logic i_arb_lost,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic o_scl_out,
	output logic o_scl_oe
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic sda_lvl, scl_lvl;
	scbi_sync u_sync_sda (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_pin(i_sda),
		.o_level(sda_lvl)
	);
	scbi_sync u_sync_scl (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_pin(i_scl),
		.o_level(scl_lvl)
	);
	logic en_reg, spie_reg, rsvd_reg, start_on_enable_option_reg, start_outcome_flag_reg, busy_reg;
	logic sda_prev_reg;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sda_prev_reg <= 1'b1;
		end else if (!en_reg) begin
			sda_prev_reg <= 1'b1;
		end else begin
			sda_prev_reg <= sda_lvl;
		end
	end
	logic start_seen, stop_seen;
	assign start_seen = sda_prev_reg && !sda_lvl && scl_lvl;
	assign stop_seen = !sda_prev_reg && sda_lvl && scl_lvl;
	// ************************************************************
	// control and configuration registers
	// ************************************************************
	logic [1:0] clk_sel_reg;
	logic [3:0] mask_reg, irq_stat_reg;
	logic wr_ctrl, start_req, stop_req, rel_req, en_rise;
	assign wr_ctrl = i_wr && (i_addr == SCBI_OFF_CTRL);
	assign start_req = wr_ctrl && i_wdata[SCBI_CTRL_START] && en_reg;
	assign stop_req = wr_ctrl && i_wdata[SCBI_CTRL_STOP] && en_reg;
	assign rel_req = wr_ctrl && i_wdata[SCBI_CTRL_REL] && en_reg;
	assign en_rise = wr_ctrl && i_wdata[SCBI_CTRL_EN] && !en_reg;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_reg <= 1'b0;
			spie_reg <= 1'b0;
		end else if (wr_ctrl) begin
			en_reg <= i_wdata[SCBI_CTRL_EN];
			spie_reg <= i_wdata[SCBI_CTRL_SPIE];
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_sel_reg <= 2'b00;
		end else if (i_wr && i_addr == SCBI_OFF_CLK && !en_reg) begin
			clk_sel_reg <= i_wdata[1:0];
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rsvd_reg <= 1'b0;
			start_on_enable_option_reg <= 1'b0;
		end else if (i_wr && i_addr == SCBI_OFF_FLAG) begin
			rsvd_reg <= i_wdata[SCBI_FLAG_RSVD];
			start_on_enable_option_reg <= i_wdata[SCBI_FLAG_START_ON_ENABLE_OPTION];
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_reg <= 4'h0;
		end else if (i_wr && i_addr == SCBI_OFF_MASK) begin
			mask_reg <= i_wdata[3:0];
		end
	end
	// ************************************************************
	// bus busy flag and participation
	// ************************************************************
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_reg <= 1'b0;
		end else if (en_rise) begin
			busy_reg <= !start_on_enable_option_reg;
		end else if (!en_reg) begin
			busy_reg <= 1'b0;
		end else if (start_seen) begin
			busy_reg <= 1'b1;
		end else if (stop_seen) begin
			busy_reg <= 1'b0;
		end
	end
	// sticky condition status, each cleared by the opposite condition
	logic start_det_reg, stop_det_reg;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_det_reg <= 1'b0;
			stop_det_reg <= 1'b0;
		end else if (!en_reg) begin
			start_det_reg <= 1'b0;
			stop_det_reg <= 1'b0;
		end else if (start_seen) begin
			start_det_reg <= 1'b1;
			stop_det_reg <= 1'b0;
		end else if (stop_seen) begin
			start_det_reg <= 1'b0;
			stop_det_reg <= 1'b1;
		end
	end
	logic idle_reg, exc_reg, master;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idle_reg <= 1'b0;
		end else if (!en_reg || stop_seen || start_seen) begin
			idle_reg <= 1'b0;
		end else if ((i_arb_lost && master) || (rel_req && exc_reg)) begin
			idle_reg <= 1'b1;
		end
	end
	// extension code is flagged by the first address nibble seen after start
	logic [3:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic scl_prev_reg;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_prev_reg <= 1'b1;
			shift_reg <= 4'h0;
			bit_cnt_reg <= 3'd0;
			exc_reg <= 1'b0;
		end else begin
			scl_prev_reg <= scl_lvl;
			if (start_seen || !en_reg) begin
				bit_cnt_reg <= 3'd0;
				exc_reg <= 1'b0;
			end else if (rel_req) begin
				exc_reg <= 1'b0;
			end else if (scl_lvl && !scl_prev_reg && bit_cnt_reg < 3'd4) begin
				shift_reg <= {shift_reg[2:0], sda_lvl};
				bit_cnt_reg <= bit_cnt_reg + 3'd1;
				if (bit_cnt_reg == 3'd3) begin
					exc_reg <= ({shift_reg[2:0], sda_lvl} == 4'h0) || ({shift_reg[2:0], sda_lvl} == SCBI_EXT_CODE);
				end
			end
		end
	end
	// ************************************************************
	// start request sequencing
	// ************************************************************
	scbi_state_e state_reg;
	logic [3:0] wait_cnt_reg;
	logic rsv_pend_reg, gen_ok_reg, go_start;
	assign go_start = (state_reg == SCBI_WAITING) && gen_ok_reg && wait_cnt_reg == 4'd1;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= SCBI_IDLE;
			wait_cnt_reg <= 4'd0;
			gen_ok_reg <= 1'b0;
		end else if (!en_reg) begin
			state_reg <= SCBI_IDLE;
		end else begin
			unique case (state_reg)
				SCBI_IDLE: begin
					if (start_req) begin
						state_reg <= SCBI_WAITING;
						wait_cnt_reg <= scbi_wait(clk_sel_reg);
						gen_ok_reg <= !(rsvd_reg && (idle_reg || busy_reg));
					end
				end
				SCBI_WAITING: begin
					wait_cnt_reg <= wait_cnt_reg - 4'd1;
					if (wait_cnt_reg == 4'd1) begin
						state_reg <= SCBI_IDLE;
					end
				end
				SCBI_HOLD: begin
					state_reg <= SCBI_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rsv_pend_reg <= 1'b0;
		end else if (!en_reg) begin
			rsv_pend_reg <= 1'b0;
		end else if (start_req && !rsvd_reg && busy_reg) begin
			rsv_pend_reg <= 1'b1;
		end else if (stop_seen) begin
			rsv_pend_reg <= 1'b0;
		end
	end
	logic pend_start;
	assign pend_start = rsv_pend_reg && stop_seen;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_outcome_flag_reg <= 1'b0;
		end else if (start_req) begin
			start_outcome_flag_reg <= 1'b0;
		end else if (go_start) begin
			start_outcome_flag_reg <= 1'b1;
		end
	end
	logic sda_oe_w, scl_oe_w;
	scbi_link u_link (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_go_start((go_start && !busy_reg) || pend_start),
		.i_go_stop(stop_req),
		.i_release(rel_req || !en_reg || (i_arb_lost && master)),
		.o_sda_oe(sda_oe_w),
		.o_scl_oe(scl_oe_w),
		.o_master(master)
	);
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sda_oe <= 1'b0;
			o_scl_oe <= 1'b0;
			o_sda_out <= 1'b0;
			o_scl_out <= 1'b0;
		end else begin
			o_sda_oe <= sda_oe_w;
			o_scl_oe <= scl_oe_w;
		end
	end
	// ************************************************************
	// interrupts and read port
	// ************************************************************
	logic [3:0] ev;
	assign ev = {start_seen && en_reg, stop_seen && en_reg && spie_reg,
		(state_reg == SCBI_WAITING) && !gen_ok_reg && wait_cnt_reg == 4'd1, go_start};
	logic rd_irq;
	assign rd_irq = i_rd && (i_addr == SCBI_OFF_IRQ);
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat_reg <= 4'h0;
			o_irq <= 1'b0;
		end else begin
			irq_stat_reg <= (rd_irq ? 4'h0 : irq_stat_reg) | ev;
			o_irq <= |(((rd_irq ? 4'h0 : irq_stat_reg) | ev) & mask_reg);
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= SCBI_RST_BYTE;
		end else if (i_rd) begin
			unique case (i_addr)
				SCBI_OFF_CTRL: o_rdata <= {en_reg, 2'b00, spie_reg, 4'h0};
				SCBI_OFF_CLK: o_rdata <= {6'h00, clk_sel_reg};
				SCBI_OFF_FLAG: o_rdata <= {start_outcome_flag_reg, busy_reg, 4'h0, start_on_enable_option_reg, rsvd_reg};
				SCBI_OFF_STAT: o_rdata <= {master, 1'b0, exc_reg, 3'h0, start_det_reg, stop_det_reg};
				SCBI_OFF_IRQ: o_rdata <= {4'h0, irq_stat_reg};
				SCBI_OFF_MASK: o_rdata <= {4'h0, mask_reg};
				default: o_rdata <= SCBI_RST_BYTE;
			endcase
		end else begin
			o_rdata <= SCBI_RST_BYTE;
		end
	end
	// ************************************************************
	// checks
	// ************************************************************
	property p_start_outcome_flag_delay;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(state_reg == SCBI_IDLE && start_req && clk_sel_reg == 2'b10 && !(rsvd_reg && (idle_reg || busy_reg)))
		|=> !start_outcome_flag_reg [*8] ##1 !start_outcome_flag_reg [*4] ##1 start_outcome_flag_reg;
	endproperty
	a_start_outcome_flag_delay: assert property (p_start_outcome_flag_delay) else $error("start flag timing wrong");
	property p_reject;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(state_reg == SCBI_IDLE && start_req && rsvd_reg && idle_reg && !rsv_pend_reg) |-> ##[1:13] !start_outcome_flag_reg;
	endproperty
	a_reject: assert property (p_reject) else $error("rejected start flagged");
	property p_en_busy;
		@(posedge i_mclk) disable iff (!i_rst_n)
		en_rise |=> busy_reg == !$past(start_on_enable_option_reg);
	endproperty
	a_en_busy: assert property (p_en_busy) else $error("busy after enable wrong");
	property p_en_free;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(en_rise && start_on_enable_option_reg) |=> !busy_reg;
	endproperty
	a_en_free: assert property (p_en_free) else $error("busy not cleared");
	property p_start_outcome_flag_master;
		@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(start_outcome_flag_reg) && !$past(busy_reg) |=> ##1 master;
	endproperty
	a_start_outcome_flag_master: assert property (p_start_outcome_flag_master) else $error("flag without start");
	property p_reserve;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(start_req && !rsvd_reg && busy_reg && !stop_seen) |=> rsv_pend_reg;
	endproperty
	a_reserve: assert property (p_reserve) else $error("reservation lost");
	property p_start_busy;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(en_reg && start_seen && !en_rise) |=> busy_reg;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start not busy");
	property p_stop_free;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(en_reg && stop_seen && !start_seen && !en_rise && !wr_ctrl) |=> !busy_reg;
	endproperty
	a_stop_free: assert property (p_stop_free) else $error("stop not freeing bus");
	property p_idle;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(en_reg && rel_req && exc_reg && !stop_seen && !start_seen && i_wdata[SCBI_CTRL_EN]) |=> idle_reg;
	endproperty
	a_idle: assert property (p_idle) else $error("release not idle");
	property p_free_start;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(go_start && !busy_reg && !stop_req && !rel_req && en_reg && !i_arb_lost) |=> master;
	endproperty
	a_free_start: assert property (p_free_start) else $error("start not driven");
endmodule // scbi_top
`default_nettype wire
